// [verification/test_pbt_top.sv]
// Self-checking bench of the periodic base timer and buzzer divider.
// Assumes pbt_top alone; a cycle model of the prescaler predicts outputs.
`timescale 1ns/1ps
`include "pbt_params.svh"
module test_pbt_top;
    // Slow mode code 0 alone needs about 33k cycles
    localparam int LIMIT = 80000;
    localparam logic [7:0] CTRL_A = `PBT_CTRL_ADDR;
    localparam int IRQ_TAP [8] = '{22, 20, 15, 13, 12, 11, 10, 8};
    logic        clk;
    logic        rst_n;
    logic        fc_tick;
    logic        fs_tick;
    logic        slow;
    logic [7:0]  awaddr;
    logic [7:0]  araddr;
    logic        awvalid;
    logic        wvalid;
    logic        bready;
    logic        arvalid;
    logic        rready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic        arready;
    logic        rvalid;
    logic        irq;
    logic        pin_n;
    logic [1:0]  bresp;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [1:0]  resp;
    logic [31:0] data;
    logic [22:0] m_cnt;
    logic [7:0]  m_ctrl;
    logic        m_armed;
    logic        m_tprev;
    logic        m_irq;
    logic        m_pin;
    logic        m_tap;
    logic        m_ok;
    logic        m_fs;
    logic [7:0]  bad_a;
    int          fail_count;
    int          cmp_count;
    int          cyc;
    int          fc_lvl;
    int          fs_lvl;
    int          irq_total = 0;

    pbt_top pbt_top_i (
        .i_core_clk             (clk),
        .i_arst_n               (rst_n),
        .i_fc_tick              (fc_tick),
        .i_fs_tick              (fs_tick),
        .i_slow_mode            (slow),
        .i_s_axil_awaddr        (awaddr),
        .i_s_axil_awvalid       (awvalid),
        .o_s_axil_awready       (awready),
        .i_s_axil_wdata         (wdata),
        .i_s_axil_wstrb         (wstrb),
        .i_s_axil_wvalid        (wvalid),
        .o_s_axil_wready        (wready),
        .o_s_axil_bresp         (bresp),
        .o_s_axil_bvalid        (bvalid),
        .i_s_axil_bready        (bready),
        .i_s_axil_araddr        (araddr),
        .i_s_axil_arvalid       (arvalid),
        .o_s_axil_arready       (arready),
        .o_s_axil_rdata         (rdata),
        .o_s_axil_rresp         (rresp),
        .o_s_axil_rvalid        (rvalid),
        .i_s_axil_rready        (rready),
        .o_periodic_irq_request (irq),
        .o_buzzer_out_pin_n     (pin_n)
    );

    function automatic int irq_tap(input logic [2:0] c);
        return IRQ_TAP[c];
    endfunction : irq_tap

    function automatic int buz_tap(input logic [1:0] c);
        return 12 - int'(c);
    endfunction : buz_tap

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Random tick enables, density set per scenario
    always @(posedge clk) begin
        fc_tick <= int'($urandom % 8) < fc_lvl;
        fs_tick <= int'($urandom % 8) < fs_lvl;
    end

    assign m_fs  = m_ctrl[4] | slow;
    assign m_tap = m_cnt[irq_tap(m_ctrl[2:0])];
    assign m_ok  = !slow || (m_ctrl[2:0] <= `PBT_SLOW_MAX_CODE);

    // model never clears prescaler on enable
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            m_cnt   <= '0;
            m_ctrl  <= `PBT_CTRL_RESET;
            m_armed <= 1'b0;
            m_tprev <= 1'b0;
            m_irq   <= 1'b0;
            m_pin   <= 1'b1;
        end else begin
            if (awvalid && awready && wvalid && wready
                && awaddr[7:2] == CTRL_A[7:2] && wstrb[0]) begin
                m_ctrl <= wdata[7:0];
            end
            if (fc_tick) begin
                m_cnt[7:0] <= m_cnt[7:0] + 8'h01;
            end
            if (m_fs ? fs_tick : (fc_tick && m_cnt[7:0] == 8'hFF)) begin
                m_cnt[22:8] <= m_cnt[22:8] + 15'h0001;
            end
            m_armed <= m_ctrl[3];
            m_tprev <= m_tap;
            m_irq   <= m_ctrl[3] & m_armed & m_ok & m_tprev & ~m_tap;
            m_pin   <= ~(m_ctrl[7] & m_cnt[buz_tap(m_ctrl[6:5])]);
        end
    end

    always @(negedge clk) begin
        if (rst_n === 1'b1) begin
            chk_bit("irq_request", m_irq, irq);
            chk_bit("buzzer_pin_n", m_pin, pin_n);
            if (irq === 1'b1) irq_total++;
        end
    end

    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            fail_count++;
            $display("mismatch timeout expected done seen hang");
            finish_test();
        end
    end

    task automatic chk_bit(input string n, input logic e, input logic s);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %b seen %b", n, e, s);
        end
    endtask : chk_bit

    task automatic chk_word(input string n, input logic [31:0] e,
                            input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk_word

    task automatic chk_resp(input string n, input logic [1:0] e,
                            input logic [1:0] s);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask : chk_resp

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [3:0] s);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge clk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= d;
        wstrb   <= s;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge clk);
            if (!ad && awready === 1'b1) begin
                awvalid <= 1'b0;
                ad = 1'b1;
            end
            if (!wd && wready === 1'b1) begin
                wvalid <= 1'b0;
                wd = 1'b1;
            end
        end while (!(ad && wd));
        do @(posedge clk); while (bvalid !== 1'b1);
        resp = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a);
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk); while (rvalid !== 1'b1);
        data = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    // Every store is read back; bits 31:8 carry random filler
    task automatic set_ctrl(input logic [7:0] v);
        axi_wr(CTRL_A, {24'($urandom()), v}, 4'hF);
        chk_resp("write_resp", `PBT_RESP_OKAY, resp);
        axi_rd(CTRL_A);
        chk_word("control", {24'h000000, v}, data);
    endtask : set_ctrl

    // Disable keeps both rate fields, enable sets rate with it
    task automatic run_code(input logic sl, input logic src,
                            input logic [2:0] c, input logic ben);
        int t;
        int n0;
        t = irq_tap(c);
        set_ctrl(m_ctrl & 8'h77);
        slow <= sl;
        fc_lvl = (sl | src) ? 7 : 8;
        fs_lvl = sl ? 8 : 4;
        set_ctrl({1'b0, c[1:0], m_ctrl[4:0]});
        set_ctrl({ben, c[1:0], src, 1'b1, c});
        n0 = irq_total;
        t = sl ? (1 << (t - 7)) : (src ? (1 << (t - 5)) : (2 << t));
        repeat (t + 64) @(posedge clk);
        chk_bit("irq_fired", !(sl && c > 3'h1), irq_total != n0);
    endtask : run_code

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        void'($urandom(32'h0654));
        {rst_n, slow, awvalid, wvalid} = '0;
        {bready, arvalid, rready, awaddr, araddr, wdata, wstrb} = '0;
        {fail_count, cmp_count, cyc} = '0;
        fc_lvl = 8;
        fs_lvl = 4;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        axi_rd(CTRL_A);
        chk_word("control_reset", 32'h00000000, data);
        do bad_a = 8'($urandom()); while (bad_a[7:2] == CTRL_A[7:2]);
        axi_wr(bad_a, $urandom(), 4'hF);
        chk_resp("unmapped_wr", `PBT_RESP_DECERR, resp);
        axi_rd(bad_a);
        chk_resp("unmapped_rd", `PBT_RESP_DECERR, resp);
        chk_word("unmapped_data", 32'h00000000, data);
        axi_wr(CTRL_A, 32'h000000FF, 4'hE);
        chk_resp("no_strobe_wr", `PBT_RESP_OKAY, resp);
        axi_rd(CTRL_A);
        chk_word("no_strobe", 32'h00000000, data);
        // Low-frequency source, all fast codes, buzzer on and off
        for (int c = 7; c >= 2; c--) begin
            run_code(1'b0, 1'b1, 3'(c), !c[0]);
        end
        // High-frequency source, codes short enough to fall
        for (int c = 7; c >= 4; c--) begin
            run_code(1'b0, 1'b0, 3'(c), 1'b1);
        end
        run_code(1'b1, 1'b0, 3'h1, 1'b1);
        run_code(1'b1, 1'b0, 3'h0, 1'b0);
        // Undefined slow code must stay silent
        run_code(1'b1, 1'b0, 3'h3, 1'b1);
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        axi_rd(CTRL_A);
        chk_word("control_rereset", 32'h00000000, data);
        finish_test();
    end
endmodule : test_pbt_top

// [verilog/pbt_axil_slave.sv]
// AXI4-Lite slave holding one 8-bit register window.
// Assumes a master that keeps at most one write and one read open.
`timescale 1ns/1ps
`include "pbt_params.svh"
module pbt_axil_slave #(
    parameter int ADDR_W = 8
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_arst_n,
    input  wire logic [ADDR_W-1:0] i_s_axil_awaddr,
    input  wire logic              i_s_axil_awvalid,
    output logic                   o_s_axil_awready,
    input  wire logic [31:0]       i_s_axil_wdata,
    input  wire logic [3:0]        i_s_axil_wstrb,
    input  wire logic              i_s_axil_wvalid,
    output logic                   o_s_axil_wready,
    output logic [1:0]             o_s_axil_bresp,
    output logic                   o_s_axil_bvalid,
    input  wire logic              i_s_axil_bready,
    input  wire logic [ADDR_W-1:0] i_s_axil_araddr,
    input  wire logic              i_s_axil_arvalid,
    output logic                   o_s_axil_arready,
    output logic [31:0]            o_s_axil_rdata,
    output logic [1:0]             o_s_axil_rresp,
    output logic                   o_s_axil_rvalid,
    input  wire logic              i_s_axil_rready,
    output logic                   o_wr_en,
    output logic [7:0]             o_wr_data,
    input  wire logic [7:0]        i_rd_data
);
    pbt_pkg::pbt_wr_state_t wst_ff, nxt_wst;
    logic              aw_ff, nxt_aw, w_ff, nxt_w;
    logic [ADDR_W-1:0] awa_ff, nxt_awa;
    logic [7:0]        wd_ff, nxt_wd;
    logic              ws_ff, nxt_ws;
    logic [1:0]        bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
    logic              rvalid_ff, nxt_rvalid;
    logic [31:0]       rdata_ff, nxt_rdata;
    logic              aw_have, w_have, hit;
    logic [ADDR_W-1:0] wa;

    // Word match only; low address bits ignored
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1:2] == ADDR_W'(`PBT_CTRL_ADDR) >> 2;
    endfunction : addr_hit

    assign o_s_axil_awready = !aw_ff && wst_ff == pbt_pkg::PBT_WR_IDLE;
    assign o_s_axil_wready  = !w_ff && wst_ff == pbt_pkg::PBT_WR_IDLE;
    assign o_s_axil_bvalid  = wst_ff == pbt_pkg::PBT_WR_RESP;
    assign o_s_axil_bresp   = bresp_ff;
    assign o_s_axil_arready = !rvalid_ff;
    assign o_s_axil_rvalid  = rvalid_ff;
    assign o_s_axil_rdata   = rdata_ff;
    assign o_s_axil_rresp   = rresp_ff;

    always_comb begin
        aw_have   = aw_ff || (i_s_axil_awvalid && o_s_axil_awready);
        w_have    = w_ff || (i_s_axil_wvalid && o_s_axil_wready);
        wa        = aw_ff ? awa_ff : i_s_axil_awaddr;
        hit       = addr_hit(wa);
        nxt_aw    = aw_have;
        nxt_w     = w_have;
        nxt_awa   = aw_ff ? awa_ff : i_s_axil_awaddr;
        nxt_wd    = w_ff ? wd_ff : i_s_axil_wdata[7:0];
        nxt_ws    = w_ff ? ws_ff : i_s_axil_wstrb[0];
        nxt_wst   = wst_ff;
        nxt_bresp = bresp_ff;
        o_wr_en   = 1'b0;
        o_wr_data = nxt_wd;
        case (wst_ff)
            pbt_pkg::PBT_WR_IDLE: begin
                if (aw_have && w_have) begin
                    o_wr_en   = hit && nxt_ws;
                    nxt_aw    = 1'b0;
                    nxt_w     = 1'b0;
                    nxt_bresp = hit ? `PBT_RESP_OKAY : `PBT_RESP_DECERR;
                    nxt_wst   = pbt_pkg::PBT_WR_RESP;
                end
            end
            pbt_pkg::PBT_WR_RESP: begin
                if (i_s_axil_bready) begin
                    nxt_wst = pbt_pkg::PBT_WR_IDLE;
                end
            end
            default: nxt_wst = pbt_pkg::PBT_WR_IDLE;
        endcase
        nxt_rvalid = rvalid_ff && !i_s_axil_rready;
        nxt_rdata  = rdata_ff;
        nxt_rresp  = rresp_ff;
        if (i_s_axil_arvalid && !rvalid_ff) begin
            nxt_rvalid = 1'b1;
            nxt_rdata  = addr_hit(i_s_axil_araddr) ? {24'h000000, i_rd_data}
                                                   : 32'h00000000;
            nxt_rresp  = addr_hit(i_s_axil_araddr) ? `PBT_RESP_OKAY
                                                   : `PBT_RESP_DECERR;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wst_ff    <= pbt_pkg::PBT_WR_IDLE;
            aw_ff     <= 1'b0;
            w_ff      <= 1'b0;
            awa_ff    <= '0;
            wd_ff     <= 8'h00;
            ws_ff     <= 1'b0;
            bresp_ff  <= `PBT_RESP_OKAY;
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= `PBT_RESP_OKAY;
        end else begin
            wst_ff    <= nxt_wst;
            aw_ff     <= nxt_aw;
            w_ff      <= nxt_w;
            awa_ff    <= nxt_awa;
            wd_ff     <= nxt_wd;
            ws_ff     <= nxt_ws;
            bresp_ff  <= nxt_bresp;
            rvalid_ff <= nxt_rvalid;
            rdata_ff  <= nxt_rdata;
            rresp_ff  <= nxt_rresp;
        end
    end
endmodule : pbt_axil_slave

// [verilog/pbt_params.svh]
// Constants of the periodic base timer and buzzer divider.
// Assumes a 100 MHz core clock and same-clock tick enables.
`ifndef PBT_PARAMS_SVH
`define PBT_PARAMS_SVH

`define PBT_CLK_PERIOD_NS 10
`define PBT_CTRL_INDEX    8'h36
`define PBT_CTRL_ADDR     8'hD8
`define PBT_CTRL_RESET    8'h00
`define PBT_BIT_BUZ_EN    7
`define PBT_BIT_BUZ_HI    6
`define PBT_BIT_BUZ_LO    5
`define PBT_BIT_SRC       4
`define PBT_BIT_IRQ_EN    3
`define PBT_BIT_RATE_HI   2
`define PBT_BIT_RATE_LO   0
`define PBT_PRE_W         23
`define PBT_PRE_LO_W      8
`define PBT_SLOW_MAX_CODE 3'h1
`define PBT_RESP_OKAY     2'h0
`define PBT_RESP_DECERR   2'h3

`endif

// [verilog/pbt_pkg.sv]
// Types of the periodic base timer block.
// Constants live in pbt_params.svh.
package pbt_pkg;

    typedef enum logic [0:0] {
        PBT_WR_IDLE = 1'b0,
        PBT_WR_RESP = 1'b1
    } pbt_wr_state_t;

    typedef logic [4:0] pbt_tap_idx_t;

endpackage : pbt_pkg

// [verilog/pbt_prescaler.sv]
// Free-running prescaler; bit k toggles every 2^k fc ticks, or bits 8 and up every 2^(k-8) fs ticks when fs is used.
// Assumes tick enables come from logic on the core clock.
`timescale 1ns/1ps
`include "pbt_params.svh"
module pbt_prescaler #(
    parameter int PRE_W = `PBT_PRE_W,
    parameter int LO_W  = `PBT_PRE_LO_W
) (
    input  wire logic             i_core_clk,
    input  wire logic             i_arst_n,
    input  wire logic             i_fc_tick,
    input  wire logic             i_fs_tick,
    input  wire logic             i_use_fs,
    output logic [PRE_W-1:0]      o_count
);
    logic [LO_W-1:0]       lo_ff, nxt_lo;
    logic [PRE_W-LO_W-1:0] hi_ff, nxt_hi;
    logic                  hi_step;

    // Slow source enters above the low stages, so taps line up
    always_comb begin
        nxt_lo  = i_fc_tick ? lo_ff + LO_W'(1) : lo_ff;
        hi_step = i_use_fs ? i_fs_tick : (i_fc_tick && &lo_ff);
        nxt_hi  = hi_step ? hi_ff + (PRE_W-LO_W)'(1) : hi_ff;
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            lo_ff <= '0;
            hi_ff <= '0;
        end else begin
            lo_ff <= nxt_lo;
            hi_ff <= nxt_hi;
        end
    end

    assign o_count = {hi_ff, lo_ff};
endmodule : pbt_prescaler

// [verilog/pbt_top.sv]
// Periodic base timer with buzzer divider output, AXI4-Lite control.
// Assumes fc and fs ticks and the slow mode level on the core clock.
//
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ps
`include "pbt_params.svh"
module pbt_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              i_core_clk,
    input  wire logic              i_arst_n,
    input  wire logic              i_fc_tick,
    input  wire logic              i_fs_tick,
    input  wire logic              i_slow_mode,
    input  wire logic [ADDR_W-1:0] i_s_axil_awaddr,
    input  wire logic              i_s_axil_awvalid,
    output logic                   o_s_axil_awready,
    input  wire logic [31:0]       i_s_axil_wdata,
    input  wire logic [3:0]        i_s_axil_wstrb,
    input  wire logic              i_s_axil_wvalid,
    output logic                   o_s_axil_wready,
    output logic [1:0]             o_s_axil_bresp,
    output logic                   o_s_axil_bvalid,
    input  wire logic              i_s_axil_bready,
    input  wire logic [ADDR_W-1:0] i_s_axil_araddr,
    input  wire logic              i_s_axil_arvalid,
    output logic                   o_s_axil_arready,
    output logic [31:0]            o_s_axil_rdata,
    output logic [1:0]             o_s_axil_rresp,
    output logic                   o_s_axil_rvalid,
    input  wire logic              i_s_axil_rready,
    output logic                   o_periodic_irq_request,
    output logic                   o_buzzer_out_pin_n
);
    logic [7:0]            ctrl_ff, nxt_ctrl;
    logic                  wr_en;
    logic [7:0]            wr_data;
    logic [`PBT_PRE_W-1:0] count;
    logic                  use_fs;
    logic                  irq_en, buz_en;
    logic [2:0]            rate_code;
    logic [1:0]            buz_code;
    logic                  rate_ok;
    logic                  tb_tap, buz_tap;
    logic                  prev_ff, nxt_prev;
    logic                  armed_ff, nxt_armed;
    logic                  irq_ff, nxt_irq;
    logic                  pin_n_ff, nxt_pin_n;
    logic                  fall;

    // Interrupt rate code to prescaler bit
    function automatic pbt_pkg::pbt_tap_idx_t tb_idx(
        input logic [2:0] code
    );
        case (code)
            3'h0:    return 5'h16;
            3'h1:    return 5'h14;
            3'h2:    return 5'h0F;
            3'h3:    return 5'h0D;
            3'h4:    return 5'h0C;
            3'h5:    return 5'h0B;
            3'h6:    return 5'h0A;
            default: return 5'h08;
        endcase
    endfunction : tb_idx

    // Buzzer rate code to prescaler bit
    function automatic pbt_pkg::pbt_tap_idx_t buz_idx(
        input logic [1:0] code
    );
        case (code)
            2'h0:    return 5'h0C;
            2'h1:    return 5'h0B;
            2'h2:    return 5'h0A;
            default: return 5'h09;
        endcase
    endfunction : buz_idx

    pbt_axil_slave #(
        .ADDR_W (ADDR_W)
    ) u_bus (
        .i_core_clk       (i_core_clk),
        .i_arst_n         (i_arst_n),
        .i_s_axil_awaddr  (i_s_axil_awaddr),
        .i_s_axil_awvalid (i_s_axil_awvalid),
        .o_s_axil_awready (o_s_axil_awready),
        .i_s_axil_wdata   (i_s_axil_wdata),
        .i_s_axil_wstrb   (i_s_axil_wstrb),
        .i_s_axil_wvalid  (i_s_axil_wvalid),
        .o_s_axil_wready  (o_s_axil_wready),
        .o_s_axil_bresp   (o_s_axil_bresp),
        .o_s_axil_bvalid  (o_s_axil_bvalid),
        .i_s_axil_bready  (i_s_axil_bready),
        .i_s_axil_araddr  (i_s_axil_araddr),
        .i_s_axil_arvalid (i_s_axil_arvalid),
        .o_s_axil_arready (o_s_axil_arready),
        .o_s_axil_rdata   (o_s_axil_rdata),
        .o_s_axil_rresp   (o_s_axil_rresp),
        .o_s_axil_rvalid  (o_s_axil_rvalid),
        .i_s_axil_rready  (i_s_axil_rready),
        .o_wr_en          (wr_en),
        .o_wr_data        (wr_data),
        .i_rd_data        (ctrl_ff)
    );

    // source select
    // Slow mode forces the low-frequency source regardless of bit 4
    assign use_fs = ctrl_ff[`PBT_BIT_SRC] || i_slow_mode;

    // free-running prescaler
    // No clear input: enabling never disturbs the count
    pbt_prescaler u_pre (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .i_fc_tick  (i_fc_tick),
        .i_fs_tick  (i_fs_tick),
        .i_use_fs   (use_fs),
        .o_count    (count)
    );

    assign irq_en    = ctrl_ff[`PBT_BIT_IRQ_EN];
    assign rate_code = ctrl_ff[`PBT_BIT_RATE_HI:`PBT_BIT_RATE_LO];
    assign buz_en    = ctrl_ff[`PBT_BIT_BUZ_EN];
    assign buz_code  = ctrl_ff[`PBT_BIT_BUZ_HI:`PBT_BIT_BUZ_LO];

    // tap decode
    // Undefined slow-mode codes give no request at all
    assign tb_tap  = count[tb_idx(rate_code)];
    assign rate_ok = !i_slow_mode || rate_code <= `PBT_SLOW_MAX_CODE;
    assign buz_tap = count[buz_idx(buz_code)];

    // rate and enable in one write
    always_comb begin
        nxt_ctrl = wr_en ? wr_data : ctrl_ff;
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ctrl_ff <= `PBT_CTRL_RESET;
        end else begin
            ctrl_ff <= nxt_ctrl;
        end
    end

    // falling edge detect
    // Armed one cycle late so a stale tap from the old rate is ignored when the rate is written with the enable
    // single-cycle request
    always_comb begin
        fall      = prev_ff && !tb_tap;
        nxt_prev  = tb_tap;
        nxt_armed = irq_en;
        nxt_irq   = armed_ff && irq_en && rate_ok && fall;
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            prev_ff  <= 1'b0;
            armed_ff <= 1'b0;
            irq_ff   <= 1'b0;
        end else begin
            prev_ff  <= nxt_prev;
            armed_ff <= nxt_armed;
            irq_ff   <= nxt_irq;
        end
    end

    assign o_periodic_irq_request = irq_ff;

    // buzzer drive
    // Idle level is high, the inactive state of the low-true pin
    always_comb begin
        nxt_pin_n = !(buz_en && buz_tap);
    end

    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            pin_n_ff <= 1'b1;
        end else begin
            pin_n_ff <= nxt_pin_n;
        end
    end

    assign o_buzzer_out_pin_n = pin_n_ff;

    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_arst_n);

    irq_single_a: assert property (
        irq_ff |=> !irq_ff
    ) else $error("request longer than one cycle");

    irq_enabled_a: assert property (
        irq_ff |-> $past(irq_en) && $past(armed_ff)
    ) else $error("request while disabled");

    irq_edge_a: assert property (
        irq_ff |-> $past(tb_tap, 2) && !$past(tb_tap)
    ) else $error("request without falling tap edge");

    irq_cause_a: assert property (
        armed_ff && irq_en && rate_ok && prev_ff && !tb_tap |=> irq_ff
    ) else $error("falling tap edge missed");

    irq_slow_a: assert property (
        irq_ff |-> !($past(i_slow_mode) && $past(rate_code) > 3'h1)
    ) else $error("request on undefined slow code");

    tb_map_a: assert property (
        rate_code == 3'h2 |-> tb_tap == count[15]
    ) else $error("rate code 2 tap wrong");

    buz_map_a: assert property (
        buz_code == 2'h3 |-> buz_tap == count[9]
    ) else $error("buzzer code 3 tap wrong");

    rst_value_a: assert property (
        $rose(i_arst_n) |-> ctrl_ff == 8'h00 && o_buzzer_out_pin_n
    ) else $error("control not cleared by reset");

    ctrl_write_a: assert property (
        wr_en |=> ctrl_ff == $past(wr_data)
    ) else $error("control write lost");

    buz_follow_a: assert property (
        buz_en |=> o_buzzer_out_pin_n == !$past(buz_tap)
    ) else $error("buzzer pin not following tap");

    buz_idle_a: assert property (
        !buz_en ##1 !buz_en |-> o_buzzer_out_pin_n
    ) else $error("buzzer pin active while disabled");

    pre_keep_a: assert property (
        $rose(irq_en) |-> count[7:0] ==
            8'($past(count[7:0]) + {7'h00, $past(i_fc_tick)})
    ) else $error("prescaler disturbed by enable");

    src_sel_a: assert property (
        !use_fs && i_fs_tick && !(i_fc_tick && &count[7:0])
            |=> count[22:8] == $past(count[22:8])
    ) else $error("slow tick reached upper stages");

    tb_code0_a: assert property (
        rate_code == 3'h0 |-> tb_tap == count[22]
    ) else $error("rate code 0 tap wrong");

    tb_code1_a: assert property (
        rate_code == 3'h1 |-> tb_tap == count[20]
    ) else $error("rate code 1 tap wrong");

    tb_code3_a: assert property (
        rate_code == 3'h3 |-> tb_tap == count[13]
    ) else $error("rate code 3 tap wrong");

    tb_code4_a: assert property (
        rate_code == 3'h4 |-> tb_tap == count[12]
    ) else $error("rate code 4 tap wrong");

    tb_code5_a: assert property (
        rate_code == 3'h5 |-> tb_tap == count[11]
    ) else $error("rate code 5 tap wrong");

    tb_code6_a: assert property (
        rate_code == 3'h6 |-> tb_tap == count[10]
    ) else $error("rate code 6 tap wrong");

    tb_code7_a: assert property (
        rate_code == 3'h7 |-> tb_tap == count[8]
    ) else $error("rate code 7 tap wrong");

    buz_code0_a: assert property (
        buz_code == 2'h0 |-> buz_tap == count[12]
    ) else $error("buzzer code 0 tap wrong");

    buz_code1_a: assert property (
        buz_code == 2'h1 |-> buz_tap == count[11]
    ) else $error("buzzer code 1 tap wrong");

    buz_code2_a: assert property (
        buz_code == 2'h2 |-> buz_tap == count[10]
    ) else $error("buzzer code 2 tap wrong");

    irq_off_a: assert property (
        !irq_en |=> !irq_ff
    ) else $error("request after disable");

    arm_delay_a: assert property (
        $rose(irq_en) |=> !irq_ff
    ) else $error("request from stale tap after enable");

    slow_src_a: assert property (
        i_slow_mode |-> use_fs
    ) else $error("slow mode not on low-frequency source");

    ctrl_hold_a: assert property (
        !wr_en |=> ctrl_ff == $past(ctrl_ff)
    ) else $error("control changed without write");

    irq_fire_c: cover property (irq_ff);
    rate_en_c: cover property (wr_en && wr_data[3] && !irq_en);
    slow_irq_c: cover property (i_slow_mode && irq_ff);
    buz_run_c: cover property (buz_en && $fell(o_buzzer_out_pin_n));
    buz_slow_c: cover property (i_slow_mode && buz_en && !pin_n_ff);
endmodule : pbt_top
